// ### verilog/ssa_setup.sv
// Purpose: setup-stage effective state and attribute interpolation setup
// Assumes: clipper loads vertex attributes before sending the object
// Notes:   vertex 0 is the provoking vertex; two cycles per attribute
`timescale 1ns/1ns
module ssa_setup #(
    parameter int unsigned FRAC_BITS = `SSA_FRAC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire ssa_pkg::ssa_ain_t in_attr,
    input  wire logic              obj_valid,
    output logic                   obj_ready,
    input  wire ssa_pkg::ssa_obj_t obj,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output ssa_pkg::ssa_coef_t     out_coef,
    output ssa_pkg::ssa_eff_t      eff
);
    localparam logic [15:0] ONE  = 16'(1 << FRAC_BITS);
    localparam logic [15:0] HALF = 16'(1 << (FRAC_BITS - 1));

    ssa_pkg::ssa_state_t s_reg;
    ssa_pkg::ssa_state_t s_next;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // constant for channel c of constant source cs
    function automatic logic [15:0] cval(input logic [1:0] cs,
                                         input int c);
        if (cs == 2'h2)
            return ONE;
        if (cs == 2'h1 && c == 3)
            return ONE;
        return 16'h0000;
    endfunction

    // fold a delta into the shortest wrap
    function automatic logic [15:0] wrapd(input logic [15:0] d,
                                          input logic en);
        if (en && $signed(d) <= -$signed({1'b0, HALF}))
            return 16'(d + ONE);
        if (en && $signed(d) >= $signed({1'b0, HALF}))
            return 16'(d - ONE);
        return d;
    endfunction

    // mapped register offset
    function automatic logic mapped(input logic [7:0] a);
        if (a[7:6] == `SSA_A_SWZ_HI)
            return a[1:0] == 2'h0;
        return a <= `SSA_A_STAT && a[1:0] == 2'h0;
    endfunction

    // ------------------------------------------------------------------
    // handshakes
    // ------------------------------------------------------------------
    assign pready    = ce && s_reg.ph;
    assign pslverr   = pready && !mapped(paddr);
    assign prdata    = s_reg.prdata;
    assign in_ready  = ce && s_reg.fsm == ssa_pkg::ST_IDLE;
    assign obj_ready = in_ready && !in_valid;
    assign out_valid = s_reg.fsm == ssa_pkg::ST_SEND;
    assign out_coef  = s_reg.out;
    assign eff       = s_reg.eff;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        hz;
        logic        dnz;
        logic        ig;
        logic        cl;
        logic [5:0]  nout;
        logic [31:0] sw;
        logic [4:0]  src;
        logic [1:0]  sel;
        logic [2:0][63:0] vv;
        logic [15:0] d1;
        logic [15:0] d2;
        logic [31:0] rd;
        hz  = 1'b0;
        dnz = 1'b0;
        ig  = 1'b0;
        cl  = 1'b0;
        nout = 6'h00;
        sw  = 32'h0000_0000;
        src = 5'h00;
        sel = 2'h0;
        vv  = '0;
        d1  = 16'h0000;
        d2  = 16'h0000;
        rd  = 32'h0000_0000;
        s_next = s_reg;

        // apb write in access phase, read data caught in setup phase
        if (psel && penable && s_reg.ph) begin
            s_next.ph = 1'b0;
            if (pwrite) begin
                unique case (paddr)
                    `SSA_A_RASTER:
                        s_next.raster = pwdata & `SSA_M_RASTER;
                    `SSA_A_DCONST: s_next.dconst = pwdata;
                    `SSA_A_DSCALE: s_next.dscale = pwdata;
                    `SSA_A_DCLAMP: s_next.dclamp = pwdata;
                    `SSA_A_MSAA:   s_next.msaa = pwdata & `SSA_M_MSAA;
                    `SSA_A_DOP:    s_next.dop = pwdata & `SSA_M_DOP;
                    `SSA_A_SETUP:
                        s_next.setup = pwdata & `SSA_M_SETUP;
                    `SSA_A_WM:     s_next.wm = pwdata & `SSA_M_WM;
                    `SSA_A_CINT:   s_next.cint = pwdata;
                    `SSA_A_WRLO:   s_next.wrap[31:0] = pwdata;
                    `SSA_A_WRHI:   s_next.wrap[63:32] = pwdata;
                    default: begin
                        if (paddr[7:6] == `SSA_A_SWZ_HI && mapped(paddr))
                            s_next.swz[paddr[5:2]] = pwdata & `SSA_M_SWZ;
                    end
                endcase
            end
        end else if (psel && !penable) begin
            s_next.ph = 1'b1;
            unique case (paddr)
                `SSA_A_RASTER: rd = s_reg.raster;
                `SSA_A_DCONST: rd = s_reg.dconst;
                `SSA_A_DSCALE: rd = s_reg.dscale;
                `SSA_A_DCLAMP: rd = s_reg.dclamp;
                `SSA_A_MSAA:   rd = s_reg.msaa;
                `SSA_A_DOP:    rd = s_reg.dop;
                `SSA_A_SETUP:  rd = s_reg.setup;
                `SSA_A_WM:     rd = s_reg.wm;
                `SSA_A_CINT:   rd = s_reg.cint;
                `SSA_A_WRLO:   rd = s_reg.wrap[31:0];
                `SSA_A_WRHI:   rd = s_reg.wrap[63:32];
                `SSA_A_STAT:
                    rd = {24'h00_0000,
                          s_reg.fsm != ssa_pkg::ST_IDLE,
                          s_reg.eff.rtir, s_reg.eff.view,
                          s_reg.eff.pos_ofs, s_reg.eff.hz_op,
                          s_reg.eff.num_ms};
                default: begin
                    if (paddr[7:6] == `SSA_A_SWZ_HI && mapped(paddr))
                        rd = s_reg.swz[paddr[5:2]];
                end
            endcase
            s_next.prdata = rd;
        end

        // effective state from the packets
        hz = |s_reg.dop[`SSA_DO_REQ];
        s_next.eff.hz_op = hz;
        s_next.eff.num_ms = hz ? s_reg.dop[`SSA_DO_NUM]
                               : s_reg.msaa[`SSA_MS_NUM];
        s_next.eff.pos_ofs = s_next.eff.num_ms != 3'h0
            && s_reg.msaa[`SSA_MS_UL]
            && (hz ? s_reg.dop[`SSA_DO_POE]
                   : s_reg.msaa[`SSA_MS_POE]);
        dnz = s_reg.dconst != `SSA_FP_ZERO
            || s_reg.dscale != `SSA_FP_ZERO;
        s_next.eff.dofs_solid = s_reg.raster[`SSA_RA_DSOL] && dnz;
        s_next.eff.dofs_wire  = s_reg.raster[`SSA_RA_DWIR] && dnz;
        s_next.eff.dofs_point = s_reg.raster[`SSA_RA_DPNT] && dnz;
        s_next.eff.front_fill = hz ? `SSA_FILL_SOLID
                                   : s_reg.raster[`SSA_RA_FFIL];
        s_next.eff.back_fill = hz ? `SSA_FILL_SOLID
                                  : s_reg.raster[`SSA_RA_BFIL];
        s_next.eff.front_cw = hz || s_reg.raster[`SSA_RA_CW];
        s_next.eff.cull = hz ? `SSA_CULL_BACK
                             : s_reg.raster[`SSA_RA_CULL];
        s_next.eff.scissor = hz ? s_reg.dop[`SSA_DO_SCIS]
                                : s_reg.raster[`SSA_RA_SCIS];
        s_next.eff.aa = hz ? s_reg.dop[`SSA_DO_SCIS]
                           : s_reg.raster[`SSA_RA_AA];
        s_next.eff.dconst  = s_reg.dconst;
        s_next.eff.dscale  = s_reg.dscale;
        s_next.eff.dclamp  = s_reg.dclamp;
        s_next.eff.stipple = s_reg.wm[`SSA_WM_STIP];
        s_next.eff.rtir = !hz
            && s_reg.raster[`SSA_RA_FSC] != `SSA_ZERO_FSC;
        s_next.eff.view = !hz && s_reg.setup[`SSA_SE_VIEW];

        // output count, capped at 32
        nout = s_reg.setup[`SSA_SE_NOUT];
        if (nout > `SSA_MAX_OUT)
            nout = `SSA_MAX_OUT;

        // object sequencing
        unique case (s_reg.fsm)
            ssa_pkg::ST_IDLE: begin
                if (in_valid && in_ready)
                    s_next.mem[in_attr.vtx][in_attr.idx] = in_attr.data;
                else if (obj_valid && obj_ready) begin
                    s_next.obj = obj;
                    s_next.k   = 6'h00;
                    // points and lines are always front facing
                    s_next.front = !obj.is_tri
                        || (obj.cw == s_reg.eff.front_cw);
                    cl = obj.is_tri
                        && (s_reg.eff.cull == `SSA_CULL_BOTH
                        || (s_reg.eff.cull == `SSA_CULL_FRONT
                            && s_next.front)
                        || (s_reg.eff.cull == `SSA_CULL_BACK
                            && !s_next.front));
                    s_next.culled = cl;
                    s_next.fsm = ssa_pkg::ST_CALC;
                end
            end
            ssa_pkg::ST_CALC: begin
                s_next.out = '0;
                s_next.out.front  = s_reg.front;
                s_next.out.culled = s_reg.culled;
                // indices forced to zero during the operation
                s_next.out.rtai = s_reg.eff.hz_op ? 11'h000
                                                  : s_reg.obj.rtai;
                s_next.out.vpi = s_reg.eff.hz_op ? 4'h0
                                                 : s_reg.obj.vpi;
                if (s_reg.culled || nout == 6'h00) begin
                    s_next.out.last = 1'b1;
                end else begin
                    s_next.out.has_attr = 1'b1;
                    s_next.out.attr = s_reg.k[4:0];
                    s_next.out.last = s_reg.k == 6'(nout - 6'h01);
                    // group of 16 picked by the output count
                    ig = s_reg.setup[`SSA_SE_SWZ]
                        && (s_reg.k[4] == (nout > `SSA_GRP));
                    sw  = s_reg.swz[s_reg.k[3:0]];
                    src = ig ? sw[`SSA_SW_SRC] : s_reg.k[4:0];
                    sel = ig ? sw[`SSA_SW_SEL] : 2'h0;
                    if (sel[0] && !s_reg.front)
                        src = 5'(src + 5'h01);
                    for (int v = 0; v < 3; v++) begin
                        vv[v] = s_reg.mem[v][src];
                        if (sel[1])
                            vv[v][15:0] = vv[v][63:48];
                        for (int c = 0; c < 4; c++) begin
                            if (ig && sw[12 + c])
                                vv[v][16*c +: 16] =
                                    cval(sw[`SSA_SW_CON], c);
                        end
                    end
                    s_next.out.a0 = vv[0];
                    for (int c = 0; c < 4; c++) begin
                        d1 = 16'(vv[1][16*c +: 16]
                                 - vv[0][16*c +: 16]);
                        d2 = 16'(vv[2][16*c +: 16]
                                 - vv[0][16*c +: 16]);
                        if (!s_reg.k[4]) begin
                            d1 = wrapd(d1,
                                 s_reg.wrap[{s_reg.k[3:0], 2'(c)}]);
                            d2 = wrapd(d2,
                                 s_reg.wrap[{s_reg.k[3:0], 2'(c)}]);
                        end
                        if (s_reg.cint[s_reg.k[4:0]]) begin
                            d1 = 16'h0000;
                            d2 = 16'h0000;
                        end
                        s_next.out.a1[16*c +: 16] = d1;
                        s_next.out.a2[16*c +: 16] = d2;
                    end
                end
                s_next.fsm = ssa_pkg::ST_SEND;
            end
            ssa_pkg::ST_SEND: begin
                if (out_ready) begin
                    s_next.k = 6'(s_reg.k + 6'h01);
                    s_next.fsm = s_reg.out.last ? ssa_pkg::ST_IDLE
                                                : ssa_pkg::ST_CALC;
                end
            end
            default: s_next.fsm = ssa_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // state register, frozen while ce is low
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg     <= '0;
            s_reg.fsm <= ssa_pkg::ST_IDLE;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end
endmodule

// ### verilog/ssa_defs.svh
// Purpose: offsets, fields, masks and reset values of the setup stage
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   byte offsets on paddr[7:0]
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SSA_A_RASTER 8'h00
`define SSA_A_DCONST 8'h04
`define SSA_A_DSCALE 8'h08
`define SSA_A_DCLAMP 8'h0C
`define SSA_A_MSAA   8'h10
`define SSA_A_DOP    8'h14
`define SSA_A_SETUP  8'h18
`define SSA_A_WM     8'h1C
`define SSA_A_CINT   8'h20
`define SSA_A_WRLO   8'h24
`define SSA_A_WRHI   8'h28
`define SSA_A_STAT   8'h2C
`define SSA_A_SWZ_HI 2'h1
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SSA_RA_DSOL  0
`define SSA_RA_DWIR  1
`define SSA_RA_DPNT  2
`define SSA_RA_FFIL  4:3
`define SSA_RA_BFIL  6:5
`define SSA_RA_CW    7
`define SSA_RA_CULL  9:8
`define SSA_RA_SCIS  10
`define SSA_RA_AA    11
`define SSA_RA_FSC   14:12
`define SSA_MS_NUM   2:0
`define SSA_MS_UL    3
`define SSA_MS_POE   4
`define SSA_DO_REQ   3:0
`define SSA_DO_SCIS  4
`define SSA_DO_NUM   7:5
`define SSA_DO_POE   8
`define SSA_SE_VIEW  0
`define SSA_SE_NOUT  13:8
`define SSA_SE_SWZ   16
`define SSA_WM_STIP  0
`define SSA_SW_SRC   4:0
`define SSA_SW_SEL   7:6
`define SSA_SW_CON   10:9
`define SSA_SW_OVR   15:12
// ----------------------------------------------------------------------
// write masks, reset values, encodings
// ----------------------------------------------------------------------
`define SSA_M_RASTER 32'h0000_7FFF
`define SSA_M_MSAA   32'h0000_001F
`define SSA_M_DOP    32'h0000_01FF
`define SSA_M_SETUP  32'h0001_3F01
`define SSA_M_WM     32'h0000_0001
`define SSA_M_SWZ    32'h0000_F6DF
`define SSA_RST_REG  32'h0000_0000
`define SSA_FILL_SOLID 2'h0
`define SSA_CULL_BOTH  2'h0
`define SSA_CULL_FRONT 2'h2
`define SSA_CULL_BACK  2'h3
`define SSA_ZERO_FSC   3'h0
`define SSA_FP_ZERO    32'h0000_0000
`define SSA_CW         16
`define SSA_FRAC       8
`define SSA_MAX_OUT    6'h20
`define SSA_GRP        6'h10
`endif

// ### verilog/ssa_pkg.sv
// Purpose: types of the setup stage
// Assumes: ssa_defs.svh for widths
// Notes:   attribute = four 16-bit fixed point components, X in low bits
`include "ssa_defs.svh"
package ssa_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CALC = 3'b010,
        ST_SEND = 3'b100
    } ssa_fsm_t;
    typedef struct packed {
        logic [1:0]  vtx;
        logic [4:0]  idx;
        logic [63:0] data;
    } ssa_ain_t;
    typedef struct packed {
        logic        cw;
        logic        is_tri;
        logic [10:0] rtai;
        logic [3:0]  vpi;
    } ssa_obj_t;
    typedef struct packed {
        logic        has_attr;
        logic [4:0]  attr;
        logic        front;
        logic        culled;
        logic        last;
        logic [10:0] rtai;
        logic [3:0]  vpi;
        logic [63:0] a0;
        logic [63:0] a1;
        logic [63:0] a2;
    } ssa_coef_t;
    typedef struct packed {
        logic        hz_op;
        logic [2:0]  num_ms;
        logic        pos_ofs;
        logic        dofs_solid;
        logic        dofs_wire;
        logic        dofs_point;
        logic [1:0]  front_fill;
        logic [1:0]  back_fill;
        logic        front_cw;
        logic [1:0]  cull;
        logic        scissor;
        logic        aa;
        logic [31:0] dconst;
        logic [31:0] dscale;
        logic [31:0] dclamp;
        logic        stipple;
        logic        rtir;
        logic        view;
    } ssa_eff_t;
    typedef struct packed {
        logic [31:0]            raster;
        logic [31:0]            dconst;
        logic [31:0]            dscale;
        logic [31:0]            dclamp;
        logic [31:0]            msaa;
        logic [31:0]            dop;
        logic [31:0]            setup;
        logic [31:0]            wm;
        logic [31:0]            cint;
        logic [63:0]            wrap;
        logic [15:0][31:0]      swz;
        logic [2:0][31:0][63:0] mem;
        ssa_fsm_t               fsm;
        logic [5:0]             k;
        ssa_obj_t               obj;
        logic                   front;
        logic                   culled;
        ssa_coef_t              out;
        ssa_eff_t               eff;
        logic [31:0]            prdata;
        logic                   ph;
    } ssa_state_t;
endpackage

// ### bench/ssa_chk_assertions.sv
// Purpose: port checks of the setup stage
// Assumes: eff fields are registered together
// Notes:   bound into ssa_setup
`timescale 1ns/1ns
module ssa_chk (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               out_valid,
    input wire logic               out_ready,
    input wire ssa_pkg::ssa_coef_t out_coef,
    input wire ssa_pkg::ssa_eff_t  eff
);
    // ----------
    // checks
    // ----------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    sequence s_held;
        out_valid && $stable(out_coef);
    endsequence
    property p_bias;
        {eff.dofs_solid, eff.dofs_wire, eff.dofs_point} != 3'h0
            |-> (eff.dconst | eff.dscale) != 32'h0000_0000;
    endproperty
    a_beat_held: assert property (s_stall |=> s_held)
        else $error("beat changed while stalled");
    a_pos_gate: assert property (eff.pos_ofs |-> eff.num_ms != 3'h0)
        else $error("offset with one sample");
    a_bias_gate: assert property (p_bias)
        else $error("bias without terms");
    a_hz_fill: assert property (eff.hz_op |-> eff.front_fill == 2'h0
        && eff.back_fill == 2'h0) else $error("fill not solid");
    a_hz_wind: assert property (eff.hz_op |-> eff.front_cw)
        else $error("winding not clockwise");
    a_hz_cull: assert property (eff.hz_op |-> eff.cull == 2'h3)
        else $error("cull not back");
    a_hz_aa: assert property (eff.hz_op |-> eff.aa == eff.scissor)
        else $error("antialias source wrong");
    a_hz_rtir: assert property (eff.hz_op |-> !eff.rtir && !eff.view)
        else $error("raster or view left on");
endmodule
bind ssa_setup ssa_chk u_chk (.pclk(pclk), .presetn(presetn),
    .out_valid(out_valid), .out_ready(out_ready), .out_coef(out_coef),
    .eff(eff));

// ### bench/ssa_far.sv
// Purpose: clipper and windower stand-in
// Assumes: one request at a time
// Notes:   slow makes the windower stall
`timescale 1ns/1ns
module ssa_far (
    input  wire logic               pclk,
    input  wire logic               in_ready,
    input  wire logic               obj_ready,
    input  wire logic               out_valid,
    input  wire ssa_pkg::ssa_coef_t out_coef,
    output logic                    in_valid,
    output ssa_pkg::ssa_ain_t       in_attr,
    output logic                    obj_valid,
    output ssa_pkg::ssa_obj_t       obj,
    output logic                    out_ready
);
    ssa_pkg::ssa_coef_t q[$];
    logic               slow = 1'b0;
    logic               hung = 1'b0;
    // idle lines at time zero
    initial begin
        in_valid = 1'b0;
        obj_valid = 1'b0;
        in_attr = '0;
        obj = '0;
        out_ready = 1'b1;
    end
    // windower: take beats, toggle ready when slow
    always @(posedge pclk) begin
        if (out_valid && out_ready)
            q.push_back(out_coef);
        out_ready <= slow ? !out_ready : 1'b1;
    end
    // clipper: load when o low, object when o high
    task automatic push(input logic o, input ssa_pkg::ssa_ain_t a,
                        input ssa_pkg::ssa_obj_t b);
        int k;
        k = 0;
        @(posedge pclk);
        obj_valid <= o;
        in_valid <= !o;
        obj <= b;
        in_attr <= a;
        do begin
            @(posedge pclk);
            k++;
        end while (!(o ? obj_ready : in_ready) && k < 40);
        if (!(o ? obj_ready : in_ready)) hung <= 1'b1;
        obj_valid <= 1'b0;
        in_valid <= 1'b0;
        obj <= ~b;
        in_attr <= ~a;
    endtask
endmodule

// ### bench/tb_top.sv
// Purpose: self-checking bench of the setup stage
// Assumes: ce held high, 10 MHz pclk
// Notes:   far side played by ssa_far
`timescale 1ns/1ns
module tb_top;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0000_0000;
    logic [31:0]        prdata, rd;
    logic               pready, pslverr, err;
    logic               hung = 1'b0;
    logic               in_valid, in_ready, obj_valid, obj_ready;
    logic               out_valid, out_ready;
    ssa_pkg::ssa_ain_t  in_attr;
    ssa_pkg::ssa_obj_t  obj, o;
    ssa_pkg::ssa_coef_t out_coef;
    ssa_pkg::ssa_eff_t  eff;
    int                 n_fail = 0;
    int                 n_tests = 0;
    always #50 pclk = ~pclk;
    ssa_setup uut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .in_valid(in_valid), .in_ready(in_ready), .in_attr(in_attr),
        .obj_valid(obj_valid), .obj_ready(obj_ready), .obj(obj),
        .out_valid(out_valid), .out_ready(out_ready),
        .out_coef(out_coef), .eff(eff));
    ssa_far far (.pclk(pclk), .in_ready(in_ready), .obj_ready(obj_ready),
        .out_valid(out_valid), .out_coef(out_coef), .in_valid(in_valid),
        .in_attr(in_attr), .obj_valid(obj_valid), .obj(obj),
        .out_ready(out_ready));
    // ----------
    // helpers
    // ----------
    task automatic check(input string nm, input logic [191:0] s,
                         input logic [191:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // cut a hang short
    always @(posedge pclk)
        if (hung || far.hung) begin
            n_fail++;
            print_verdict();
        end
    // apb transfer, waits for pready at most 20 cycles
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (!pready && k < 20);
        if (!pready) hung <= 1'b1;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ld(input logic [4:0] i, input logic [63:0] d0, d1, d2);
        far.push(1'b0, '{2'h0, i, d0}, '0);
        far.push(1'b0, '{2'h1, i, d1}, '0);
        far.push(1'b0, '{2'h2, i, d2}, '0);
    endtask
    function automatic logic [23:0] hdr(input logic h, f, c, l,
        input logic [4:0] a, input logic [10:0] r, input logic [3:0] v);
        return {h, a, f, c, l, r, v};
    endfunction
    // wait for a beat, then compare the oldest
    task automatic beat(input string nm, input logic [23:0] h,
                        input logic [191:0] v);
        ssa_pkg::ssa_coef_t c;
        int k;
        for (k = 0; k < 200 && far.q.size() == 0; k++)
            @(posedge pclk);
        if (far.q.size() == 0) hung = 1'b1;
        c = far.q.pop_front();
        check(nm, hdr(c.has_attr, c.front, c.culled, c.last, c.attr,
              c.rtai, c.vpi), h);
        check(nm, {c.a0, c.a1, c.a2}, v);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_regs();
        check("eff_rst", eff, '0);
        apb(1'b1, 8'h00, 32'hFFFF_FFFF);
        apb(1'b0, 8'h00, 32'h0000_0000);
        check("raster_mask", rd, 32'h0000_7FFF);
        apb(1'b0, 8'h30, 32'h0000_0000);
        check("unmapped", {err, rd}, {1'b1, 32'h0000_0000});
    endtask
    task automatic t_eff();
        int i;
        apb(1'b1, 8'h00, 32'h0000_11CF);
        apb(1'b1, 8'h10, 32'h0000_001A);
        apb(1'b1, 8'h18, 32'h0000_0001);
        apb(1'b1, 8'h1C, 32'h0000_0001);
        apb(1'b1, 8'h0C, 32'h1234_5678);
        repeat (2) @(negedge pclk);
        check("bias", {eff.dofs_solid, eff.dofs_wire, eff.dofs_point,
              eff.pos_ofs, eff.num_ms}, 7'h0A);
        check("fill", {eff.front_fill, eff.back_fill, eff.front_cw,
              eff.cull}, {2'h1, 2'h2, 1'b1, 2'h1});
        check("misc", {eff.scissor, eff.aa, eff.stipple, eff.rtir,
              eff.view, eff.hz_op}, 6'h0E);
        check("dclamp", eff.dclamp, 32'h1234_5678);
        apb(1'b1, 8'h08, 32'h0000_0100);
        apb(1'b1, 8'h10, 32'h0000_0012);
        repeat (2) @(negedge pclk);
        check("bias_on", {eff.dofs_solid, eff.dofs_wire, eff.dofs_point,
              eff.pos_ofs}, 4'hE);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 8'h14, 32'h0000_0070 | (32'h0000_0001 << i));
            repeat (2) @(negedge pclk);
            check("hz", {eff.hz_op, eff.num_ms, eff.scissor, eff.aa,
                  eff.front_fill, eff.back_fill, eff.front_cw, eff.cull,
                  eff.rtir, eff.view}, 15'h5E1C);
        end
        apb(1'b1, 8'h14, 32'h0000_0000);
    endtask
    task automatic t_coef();
        o = '{1'b1, 1'b1, 11'h005, 4'h3};
        apb(1'b1, 8'h18, 32'h0000_0201);
        apb(1'b1, 8'h20, 32'h0000_0002);
        apb(1'b1, 8'h24, 32'h0000_0001);
        ld(5'h00, 64'h0000, 64'h0080, 64'h0010);
        ld(5'h01, 64'h0010_0010_0010_0010, 64'h0020_0020_0020_0020,
           64'h0030_0030_0030_0030);
        far.slow = 1'b1;
        far.push(1'b1, '0, o);
        beat("wrap", hdr(1, 1, 0, 0, 5'h00, 11'h005, 4'h3),
             {64'h0000, 64'hFF80, 64'h0010});
        beat("const", hdr(1, 1, 0, 1, 5'h01, 11'h005, 4'h3),
             {64'h0010_0010_0010_0010, 128'h0000});
        far.slow = 1'b0;
    endtask
    task automatic t_swz();
        apb(1'b1, 8'h00, 32'h0000_114F);
        apb(1'b1, 8'h18, 32'h0001_0201);
        apb(1'b1, 8'h20, 32'h0000_0000);
        apb(1'b1, 8'h24, 32'h0000_0000);
        apb(1'b1, 8'h40, 32'h0000_00C0);
        apb(1'b1, 8'h44, 32'h0000_F200);
        ld(5'h00, 64'h0004_0003_0002_0001, 64'h0004_0003_0002_0001,
           64'h0004_0003_0002_0001);
        ld(5'h01, 64'h0008_0007_0006_0005, 64'h0008_0007_0006_0005,
           64'h0008_0007_0006_0005);
        far.push(1'b1, '0, o);
        beat("back_w", hdr(1, 0, 0, 0, 5'h00, 11'h005, 4'h3),
             {64'h0008_0007_0006_0008, 128'h0000});
        beat("ovr", hdr(1, 0, 0, 1, 5'h01, 11'h005, 4'h3),
             {64'h0100_0000_0000_0000, 128'h0000});
    endtask
    task automatic t_hz();
        ssa_pkg::ssa_coef_t c;
        apb(1'b1, 8'h14, 32'h0000_0001);
        apb(1'b0, 8'h2C, 32'h0000_0000);
        check("stat", rd, 32'h0000_0008);
        far.push(1'b1, '0, o);
        beat("hz_front", hdr(1, 1, 0, 0, 5'h00, 11'h000, 4'h0),
             {64'h0004_0003_0002_0004, 128'h0000});
        beat("hz_ovr", hdr(1, 1, 0, 1, 5'h01, 11'h000, 4'h0),
             {64'h0100_0000_0000_0000, 128'h0000});
        o.cw = 1'b0;
        far.push(1'b1, '0, o);
        repeat (20) @(posedge pclk);
        c = far.q.pop_front();
        check("culled", {c.has_attr, c.culled, c.last}, 3'h3);
        check("one_beat", far.q.size(), 0);
    endtask
    // reset, then scenarios in order
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(negedge pclk);
        t_regs();
        t_eff();
        t_coef();
        t_swz();
        t_hz();
        print_verdict();
    end
endmodule
